// ===== rtl/fsw_defs.svh
// Purpose: bit positions, reset values and fixed figures of the status word
// Assumes: included by its bare name from every file that needs it
// Notes:   definitions only
`ifndef FSW_DEFS_SVH
`define FSW_DEFS_SVH
`define FSW_WIDTH 16
`define FSW_EXC_LSB 0
`define FSW_EXC_MSB 5
`define FSW_SF_BIT 6
`define FSW_ES_BIT 7
`define FSW_C0_BIT 8
`define FSW_C1_BIT 9
`define FSW_C2_BIT 10
`define FSW_TOP_LSB 11
`define FSW_TOP_MSB 13
`define FSW_C3_BIT 14
`define FSW_B_BIT 15
`define FSW_RESET_WORD 16'h0000
`define FSW_NO_EXC 6'h00
`define FSW_IE_ONEHOT 6'h01
`define FSW_CC_CLEAR 4'h0
`define FSW_TOP_RESET 3'h0
`define FSW_TOP_MAX 3'h7
`define FSW_TOP_STEP 3'h1
`endif

// ===== rtl/fsw_pkg.sv
// Purpose: types shared by the status-word logic and its datapath
// Assumes: constants live in fsw_defs.svh
// Notes:   none
package fsw_pkg;

	// --------------------------------------------------------------
	// instruction classes reported at completion
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		FSW_OP_NONE,
		FSW_OP_ARITH,
		FSW_OP_PUSH_LOAD,
		FSW_OP_POP_STORE,
		FSW_OP_EXAMINE,
		FSW_OP_PREM,
		FSW_OP_TRIG,
		FSW_OP_COMPARE,
		FSW_OP_FLAG_COMPARE,
		FSW_OP_ENV_LOAD,
		FSW_OP_RESTORE,
		FSW_OP_CLEX,
		FSW_OP_INIT,
		FSW_OP_SAVE,
		FSW_OP_STATUS_STORE
	} fsw_op_t;

	// --------------------------------------------------------------
	// completion record from the datapath
	// --------------------------------------------------------------
	typedef struct packed {
		fsw_op_t op;
		logic [5:0] exc;          // exceptions detected, bit order as status word
		logic stk_fault;          // register stack overflow or underflow
		logic stk_ovf;            // 1 overflow, 0 underflow
		logic round_up;           // last rounding went upward
		logic [2:0] cc_result;    // {c3,c2,c0}: compare result or operand class
		logic sign;               // sign of the examined operand
		logic [2:0] quot;         // low quotient bits of a remainder
		logic incomplete;         // remainder reduction not finished
		logic out_of_range;       // trig source beyond range
		logic to_acc;             // status store goes to the accumulator
	} fsw_event_t;

	// --------------------------------------------------------------
	// status store output
	// --------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic to_acc;
		logic [15:0] data;
	} fsw_store_t;

endpackage : fsw_pkg

// ===== rtl/fsw_top_ptr.sv
// Purpose: top-of-stack pointer of the register stack
// Assumes: at most one of push, pop, load, clear per cycle
// Notes:   arithmetic is 3 bits wide, so wrap is natural
`timescale 1ns/100ps
`include "fsw_defs.svh"

module fsw_top_ptr (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic load,
	input wire logic [2:0] load_val,
	input wire logic clear,
	output logic [2:0] top
);

	logic [2:0] top_r;
	logic [2:0] top_nxt;

	// --------------------------------------------------------------
	// next pointer
	// --------------------------------------------------------------
	// push decrements before the write, 0 wraps to 7; pop increments after read
	assign top_nxt = clear ? `FSW_TOP_RESET :
		load ? load_val :
		push ? top_r - `FSW_TOP_STEP :
		pop ? top_r + `FSW_TOP_STEP :
		top_r;

	// pointer register
	always_ff @(posedge clk) begin
		if (rst) begin
			top_r <= `FSW_TOP_RESET;
		end else begin
			top_r <= top_nxt;
		end
	end

	assign top = top_r;

endmodule : fsw_top_ptr

// ===== rtl/fsw_status_word.sv
// Purpose: status word of the stack floating-point unit
// Assumes: one completion record per EVT_DONE pulse, inputs synchronous to CLK
// Notes:   all fields of one instruction update on the same edge
`timescale 1ns/100ps
`include "fsw_defs.svh"

module fsw_status_word (
	input wire logic CLK,
	input wire logic RST,
	input wire logic EVT_DONE,
	input wire fsw_pkg::fsw_event_t EVT,
	input wire logic [5:0] EXC_MASK,
	input wire logic [15:0] LOAD_IMAGE,
	input wire logic BUSY_IN,
	output logic [15:0] STATUS_WORD,
	output logic ERROR_SUMMARY,
	output logic BUSY,
	output fsw_pkg::fsw_store_t STORE
);

	// --------------------------------------------------------------
	// functions
	// --------------------------------------------------------------

	// assemble a status word from its fields
	function automatic logic [15:0] pack_word(
		input logic [5:0] flags,
		input logic sf,
		input logic es,
		input logic [3:0] cc,
		input logic [2:0] top
	);
		logic [15:0] w;
		w = `FSW_RESET_WORD;
		w[`FSW_EXC_MSB:`FSW_EXC_LSB] = flags;
		w[`FSW_SF_BIT] = sf;
		w[`FSW_ES_BIT] = es;
		w[`FSW_C0_BIT] = cc[0];
		w[`FSW_C1_BIT] = cc[1];
		w[`FSW_C2_BIT] = cc[2];
		w[`FSW_C3_BIT] = cc[3];
		w[`FSW_TOP_MSB:`FSW_TOP_LSB] = top;
		w[`FSW_B_BIT] = es;
		return w;
	endfunction : pack_word

	// condition codes {c3,c2,c1,c0} after one instruction
	function automatic logic [3:0] cc_update(
		input fsw_pkg::fsw_event_t e,
		input logic [3:0] cc_old
	);
		logic [3:0] cc;
		logic c1_round;
		cc = cc_old;
		c1_round = e.exc[`FSW_EXC_MSB] & e.round_up;
		case (e.op)
			fsw_pkg::FSW_OP_ARITH, fsw_pkg::FSW_OP_PUSH_LOAD, fsw_pkg::FSW_OP_POP_STORE: begin
				cc[1] = c1_round;
			end
			fsw_pkg::FSW_OP_EXAMINE: begin
				cc = {e.cc_result[2], e.cc_result[1], e.sign, e.cc_result[0]};
			end
			fsw_pkg::FSW_OP_PREM: begin
				cc[2] = e.incomplete;
				if (!e.incomplete) begin
					cc[0] = e.quot[2];
					cc[3] = e.quot[1];
					cc[1] = e.quot[0];
				end
			end
			fsw_pkg::FSW_OP_TRIG: begin
				cc[2] = e.out_of_range;
				if (!e.out_of_range) begin
					cc[1] = c1_round;
				end
			end
			fsw_pkg::FSW_OP_COMPARE: begin
				cc = {e.cc_result[2], e.cc_result[1], 1'b0, e.cc_result[0]};
			end
			fsw_pkg::FSW_OP_FLAG_COMPARE: begin
				cc[1] = 1'b0;
			end
			fsw_pkg::FSW_OP_INIT, fsw_pkg::FSW_OP_SAVE: begin
				cc = `FSW_CC_CLEAR;
			end
			default: begin
				cc = cc_old;
			end
		endcase
		// a stack fault overrides cond_code_1 with its direction
		if (e.stk_fault) begin
			cc[1] = e.stk_ovf;
		end
		return cc;
	endfunction : cc_update

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [5:0] flags_r;
	logic [5:0] flags_nxt;
	logic sf_r;
	logic sf_nxt;
	logic es_r;
	logic es_nxt;
	logic [3:0] cc_r;
	logic [3:0] cc_nxt;
	logic [3:0] cc_calc;
	logic busy_r;
	logic [2:0] top;
	logic [15:0] word;
	fsw_pkg::fsw_store_t store_r;
	fsw_pkg::fsw_store_t store_nxt;

	// --------------------------------------------------------------
	// instruction decode
	// --------------------------------------------------------------
	wire op_load = EVT_DONE && (EVT.op == fsw_pkg::FSW_OP_ENV_LOAD || EVT.op == fsw_pkg::FSW_OP_RESTORE);
	wire op_reinit = EVT_DONE && (EVT.op == fsw_pkg::FSW_OP_INIT || EVT.op == fsw_pkg::FSW_OP_SAVE);
	wire op_clex = EVT_DONE && EVT.op == fsw_pkg::FSW_OP_CLEX;
	wire op_push = EVT_DONE && EVT.op == fsw_pkg::FSW_OP_PUSH_LOAD;
	wire op_pop = EVT_DONE && EVT.op == fsw_pkg::FSW_OP_POP_STORE;
	wire op_stsw = EVT_DONE && EVT.op == fsw_pkg::FSW_OP_STATUS_STORE;
	wire stk_evt = EVT_DONE && EVT.stk_fault;
	wire [5:0] exc_set = EVT_DONE ? (EVT.exc | (EVT.stk_fault ? `FSW_IE_ONEHOT : `FSW_NO_EXC)) : `FSW_NO_EXC;

	// --------------------------------------------------------------
	// next values of the flag fields
	// --------------------------------------------------------------
	// exceptions accumulate; only clear, reinit or an image load remove them
	assign flags_nxt = op_load ? LOAD_IMAGE[`FSW_EXC_MSB:`FSW_EXC_LSB] :
		(op_reinit || op_clex) ? `FSW_NO_EXC :
		flags_r | exc_set;
	// stack fault: set on fault, kept on plain invalid, cleared explicitly
	assign sf_nxt = op_load ? LOAD_IMAGE[`FSW_SF_BIT] :
		(op_reinit || op_clex) ? 1'b0 :
		sf_r | stk_evt;
	// summary only from flags whose control mask bit is clear
	assign es_nxt = |(flags_nxt & ~EXC_MASK);
	// condition codes, from image on a load or from the result
	assign cc_calc = cc_update(EVT, cc_r);
	assign cc_nxt = op_load ? {LOAD_IMAGE[`FSW_C3_BIT], LOAD_IMAGE[`FSW_C2_BIT],
		LOAD_IMAGE[`FSW_C1_BIT], LOAD_IMAGE[`FSW_C0_BIT]} :
		EVT_DONE ? cc_calc : cc_r;

	// --------------------------------------------------------------
	// store path: word before this instruction's own update
	// --------------------------------------------------------------
	assign store_nxt.valid = op_stsw || (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_SAVE);
	assign store_nxt.to_acc = op_stsw && EVT.to_acc;
	assign store_nxt.data = word;

	// --------------------------------------------------------------
	// registers, all fields on one edge
	// --------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			flags_r <= `FSW_NO_EXC;
			sf_r <= 1'b0;
			es_r <= 1'b0;
			cc_r <= `FSW_CC_CLEAR;
			busy_r <= 1'b0;
			store_r <= '0;
		end else begin
			flags_r <= flags_nxt;
			sf_r <= sf_nxt;
			es_r <= es_nxt;
			cc_r <= cc_nxt;
			busy_r <= BUSY_IN;
			store_r <= store_nxt;
		end
	end

	// --------------------------------------------------------------
	// top-of-stack pointer
	// --------------------------------------------------------------
	fsw_top_ptr u_top (
		.clk(CLK),
		.rst(RST),
		.push(op_push),
		.pop(op_pop),
		.load(op_load),
		.load_val(LOAD_IMAGE[`FSW_TOP_MSB:`FSW_TOP_LSB]),
		.clear(op_reinit),
		.top(top)
	);

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	// bit 15 repeats the summary, top lands in bits 11 to 13
	assign word = pack_word(flags_r, sf_r, es_r, cc_r, top);
	assign STATUS_WORD = word;
	assign ERROR_SUMMARY = es_r;  // handler request
	assign BUSY = busy_r;
	assign STORE = store_r;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// reset must leave word and strobes at zero, so this one ignores the default disable
	a_reset_clear: assert property (@(posedge CLK) disable iff (1'b0) RST
		|=> word == `FSW_RESET_WORD && !STORE.valid && !BUSY)
		else $error("reset did not clear status word");

	// --------------------------------------------------------------
	// top-of-stack pointer
	// --------------------------------------------------------------
	a_top_push_wrap: assert property (op_push && top == `FSW_TOP_RESET |=> top == `FSW_TOP_MAX)
		else $error("push from top 0 did not wrap to 7");

	a_top_push_step: assert property (op_push |=> top == $past(top) - `FSW_TOP_STEP)
		else $error("push did not decrement top");

	a_top_pop_step: assert property (op_pop |=> top == $past(top) + `FSW_TOP_STEP)
		else $error("pop did not increment top");

	// --------------------------------------------------------------
	// condition codes
	// --------------------------------------------------------------
	// a stack fault direction overrides every other use of cond_code_1 except an image load
	a_c1_fault_dir: assert property (stk_evt && !(op_load || op_reinit || op_clex)
		|=> word[`FSW_C1_BIT] == $past(EVT.stk_ovf) && sf_r)
		else $error("stack fault direction not in cond_code_1");

	a_inexact_c1: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_ARITH && !EVT.stk_fault
		|=> cc_r[1] == $past(EVT.exc[`FSW_EXC_MSB] & EVT.round_up))
		else $error("cond_code_1 does not show the rounding direction");

	a_exam_class: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_EXAMINE && !EVT.stk_fault
		|=> word[`FSW_C1_BIT] == $past(EVT.sign) && word[`FSW_C3_BIT] == $past(EVT.cc_result[2])
		&& word[`FSW_C2_BIT] == $past(EVT.cc_result[1]) && word[`FSW_C0_BIT] == $past(EVT.cc_result[0]))
		else $error("examine did not report sign and class");

	a_prem_partial: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_PREM && EVT.incomplete
		|=> word[`FSW_C2_BIT])
		else $error("incomplete remainder did not set cond_code_2");

	a_prem_quot: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_PREM
		&& !EVT.incomplete && !EVT.stk_fault
		|=> {cc_r[0], cc_r[3], cc_r[1], cc_r[2]} == {$past(EVT.quot), 1'b0})
		else $error("completed remainder quotient bits wrong");

	a_trig_range: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_TRIG
		|=> word[`FSW_C2_BIT] == $past(EVT.out_of_range))
		else $error("trig range flag wrong");

	a_trig_round: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_TRIG
		&& !EVT.out_of_range && !EVT.stk_fault
		|=> cc_r[1] == $past(EVT.exc[`FSW_EXC_MSB] & EVT.round_up))
		else $error("in-range trig did not set cond_code_1 from rounding");

	a_compare_cc: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_COMPARE && !EVT.stk_fault
		|=> cc_r == {$past(EVT.cc_result[2:1]), 1'b0, $past(EVT.cc_result[0])})
		else $error("compare result not encoded in condition codes");

	a_flagcmp_c1: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_FLAG_COMPARE
		|=> cc_r[1] == $past(EVT.stk_fault && EVT.stk_ovf))
		else $error("flag compare misused cond_code_1");

	a_image_load: assert property (op_load
		|=> word[`FSW_C3_BIT:`FSW_C0_BIT] == $past(LOAD_IMAGE[`FSW_C3_BIT:`FSW_C0_BIT])
		&& word[`FSW_SF_BIT:`FSW_EXC_LSB] == $past(LOAD_IMAGE[`FSW_SF_BIT:`FSW_EXC_LSB]))
		else $error("image load not copied into status word");

	a_reinit_clear: assert property (op_reinit
		|=> cc_r == `FSW_CC_CLEAR && flags_r == `FSW_NO_EXC && !sf_r && top == `FSW_TOP_RESET)
		else $error("init or save did not clear fields");

	// --------------------------------------------------------------
	// exception flags, stack fault and summary
	// --------------------------------------------------------------
	// clear, reinit and image loads are the only ways a flag may fall
	a_sf_set: assert property (stk_evt && !(op_load || op_reinit || op_clex)
		|=> sf_r && flags_r[`FSW_EXC_LSB])
		else $error("stack fault did not set stack_fault and invalid");

	a_sf_kept: assert property (EVT_DONE && EVT.exc[`FSW_EXC_LSB] && !EVT.stk_fault
		&& !(op_load || op_reinit || op_clex) |=> sf_r == $past(sf_r))
		else $error("plain invalid changed stack_fault");

	a_flags_sticky: assert property (!(op_load || op_reinit || op_clex)
		|=> (flags_r & $past(flags_r)) == $past(flags_r) && (sf_r || !$past(sf_r)))
		else $error("sticky flag dropped without clear");

	a_clex_clear: assert property (op_clex |=> flags_r == `FSW_NO_EXC && !sf_r)
		else $error("clear exceptions left a flag set");

	a_masked_flag: assert property (EVT_DONE && (EVT.exc & EXC_MASK) != `FSW_NO_EXC
		&& !(op_load || op_reinit || op_clex) |=> (flags_r & $past(EVT.exc)) == $past(EVT.exc))
		else $error("detected exception did not set its flag");

	a_summary_mask: assert property (##1 es_r == |(flags_r & ~$past(EXC_MASK)))
		else $error("summary disagrees with unmasked flags");

	a_b_mirror: assert property (word[`FSW_B_BIT] == es_r)
		else $error("bit 15 does not mirror summary");

	// --------------------------------------------------------------
	// store path and busy
	// --------------------------------------------------------------
	a_store_word: assert property (store_nxt.valid
		|=> STORE.valid && STORE.data == $past(word) ##1 !STORE.valid || $past(store_nxt.valid, 1))
		else $error("status store data or strobe wrong");

	a_store_dest: assert property (op_stsw |=> STORE.valid && STORE.to_acc == $past(EVT.to_acc))
		else $error("status store went to the wrong place");

	a_save_mem: assert property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_SAVE
		|=> STORE.valid && !STORE.to_acc)
		else $error("save did not store the word to memory");

	a_busy_follow: assert property (##1 BUSY == $past(BUSY_IN))
		else $error("busy flag does not follow the datapath");

	// --------------------------------------------------------------
	// main scenarios
	// --------------------------------------------------------------
	c_push_wrap: cover property (op_push && top == `FSW_TOP_RESET);
	c_masked_exc: cover property (EVT_DONE && (EVT.exc & EXC_MASK) != `FSW_NO_EXC ##1 !es_r);
	c_store_acc: cover property (op_stsw && EVT.to_acc);
	c_fault_then_clex: cover property (stk_evt ##[1:20] op_clex);
	c_prem_partial: cover property (EVT_DONE && EVT.op == fsw_pkg::FSW_OP_PREM && EVT.incomplete);

endmodule : fsw_status_word

// ===== bench/fsw_datapath_model.sv
// Purpose: stand-in for the datapath that reports instruction completions
// Assumes: the bench decides when an instruction completes
// Notes:   the record is scrambled outside the strobe, never left at its last value
`timescale 1ns/100ps

module fsw_datapath_model (
	input wire logic req,
	input wire fsw_pkg::fsw_event_t req_evt,
	output logic done,
	output fsw_pkg::fsw_event_t evt
);
	// ------------------------------------------------------------
	// completion strobe and record
	// ------------------------------------------------------------
	// idle cycles show the inverse so a stale record cannot pass for a new one
	assign done = req;
	assign evt = req ? req_evt : ~req_evt;
endmodule : fsw_datapath_model

// ===== bench/fp_status_word_logic_tb.sv
// Purpose: self-checking bench of the status word against a reference model
// Assumes: one completion per cycle at most, result checked half a cycle after the taking edge
// Notes:   undefined condition-code bits are masked out of the word compare
`timescale 1ns/100ps

module fp_status_word_logic_tb;
	logic clk = 1'b0, rst = 1'b1, req = 1'b0, busy_in = 1'b0;
	logic [5:0] exc_mask = 6'h00;
	logic [15:0] load_image = 16'h0000, status_word;
	logic done, error_summary, busy;
	fsw_pkg::fsw_event_t req_evt = '0, evt, e, e_old;
	fsw_pkg::fsw_store_t store;
	int seed = 62597, failures = 0, checks_done = 0, cyc = 0;
	// reference state: {c3,c2,c1,c0} and which of them are defined
	logic [5:0] fl, mk_old;
	logic sf, es, pst, pacc, go, go_old, b_old;
	logic [3:0] cc, kn;
	logic [2:0] top;
	logic [15:0] ew, km, pdat, pkm, img_old;

	always #50 clk = ~clk;

	fsw_datapath_model PARTNER (.req(req), .req_evt(req_evt), .done(done), .evt(evt));

	fsw_status_word DUT (.CLK(clk), .RST(rst), .EVT_DONE(done), .EVT(evt), .EXC_MASK(exc_mask),
		.LOAD_IMAGE(load_image), .BUSY_IN(busy_in), .STATUS_WORD(status_word),
		.ERROR_SUMMARY(error_summary), .BUSY(busy), .STORE(store));

	task automatic check16(input logic [15:0] g, input logic [15:0] x);
		checks_done++;
		if (g !== x) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask : check16

	task automatic check1(input logic g, input logic x);
		check16({15'h0000, g}, {15'h0000, x});
	endtask : check1

	task automatic give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// reference update for one completed instruction
	task automatic apply(input fsw_pkg::fsw_event_t v, input logic [15:0] img);
		if (v.op == fsw_pkg::FSW_OP_SAVE || v.op == fsw_pkg::FSW_OP_STATUS_STORE) begin
			pst = 1'b1;
			pacc = (v.op == fsw_pkg::FSW_OP_STATUS_STORE) & v.to_acc;
			pdat = ew;
			pkm = km;
		end
		fl = fl | v.exc | {5'h00, v.stk_fault};
		sf = sf | v.stk_fault;
		case (v.op)
			fsw_pkg::FSW_OP_ARITH, fsw_pkg::FSW_OP_PUSH_LOAD, fsw_pkg::FSW_OP_POP_STORE: begin
				cc[1] = v.exc[5] & v.round_up;
				kn = 4'h2;
				if (v.op == fsw_pkg::FSW_OP_PUSH_LOAD) top = top - 3'h1;
				if (v.op == fsw_pkg::FSW_OP_POP_STORE) top = top + 3'h1;
			end
			fsw_pkg::FSW_OP_EXAMINE: begin
				cc = {v.cc_result[2:1], v.sign, v.cc_result[0]};
				kn = 4'hf;
			end
			fsw_pkg::FSW_OP_PREM: begin
				cc[2] = v.incomplete;
				kn[2] = 1'b1;
				if (!v.incomplete) begin
					cc = {v.quot[1], 1'b0, v.quot[0], v.quot[2]};
					kn = 4'hf;
				end
			end
			fsw_pkg::FSW_OP_TRIG: begin
				cc[2] = v.out_of_range;
				kn = (kn & 4'h2) | 4'h4;
				if (!v.out_of_range) begin
					cc[1] = v.exc[5] & v.round_up;
					kn[1] = 1'b1;
				end
			end
			fsw_pkg::FSW_OP_COMPARE: begin
				cc = {v.cc_result[2:1], 1'b0, v.cc_result[0]};
				kn = 4'hf;
			end
			fsw_pkg::FSW_OP_FLAG_COMPARE: begin
				cc[1] = 1'b0;
				kn[1] = 1'b1;
			end
			fsw_pkg::FSW_OP_ENV_LOAD, fsw_pkg::FSW_OP_RESTORE: begin
				{fl, sf, top} = {img[5:0], img[6], img[13:11]};
				cc = {img[14], img[10:8]};
				kn = 4'hf;
			end
			fsw_pkg::FSW_OP_CLEX: {fl, sf} = 7'h00;
			fsw_pkg::FSW_OP_INIT, fsw_pkg::FSW_OP_SAVE: begin
				{fl, sf, cc, top} = 14'h0000;
				kn = 4'hf;
			end
			default: ;
		endcase
		if (v.stk_fault) begin
			cc[1] = v.stk_ovf;
			kn[1] = 1'b1;
		end
	endtask : apply

	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			give_verdict();
		end
	end

	initial begin
		{fl, sf, cc, top, mk_old, go_old, b_old, pst} = '0;
		kn = 4'hf;
		img_old = 16'h0000;
		e_old = '0;
		repeat (3) @(posedge clk);
		// outputs must read zero while reset is held
		@(negedge clk);
		check16(status_word, 16'h0000);
		check1(store.valid | error_summary | busy, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 1200; i++) begin
			@(posedge clk);
			e = fsw_pkg::fsw_event_t'($bits(fsw_pkg::fsw_event_t)'($random(seed)));
			e.op = fsw_pkg::fsw_op_t'(4'($unsigned($random(seed)) % 15));
			e.exc = e.exc & 6'($random(seed));
			e.stk_fault = e.stk_fault & ~|2'($random(seed));
			go = |2'($random(seed)) || i == 0;
			// first instruction pushes from top 0 to check the wrap to 7
			if (i == 0) e.op = fsw_pkg::FSW_OP_PUSH_LOAD;
			if (e.op inside {fsw_pkg::FSW_OP_NONE, fsw_pkg::FSW_OP_ENV_LOAD, fsw_pkg::FSW_OP_RESTORE,
				fsw_pkg::FSW_OP_CLEX, fsw_pkg::FSW_OP_INIT, fsw_pkg::FSW_OP_SAVE,
				fsw_pkg::FSW_OP_STATUS_STORE} || i == 0) begin
				e.exc = 6'h00;
				e.stk_fault = 1'b0;
			end
			req <= go;
			req_evt <= e;
			exc_mask <= 6'($random(seed));
			load_image <= 16'($random(seed));
			busy_in <= 1'($random(seed));
			@(negedge clk);
			// model the instruction that the last edge took, before comparing what it left
			if (go_old) apply(e_old, img_old);
			es = |(fl & ~mk_old);
			ew = {es, cc[3], top, cc[2:0], es, sf, fl};
			km = {1'b1, kn[3], 3'h7, kn[2:0], 8'hff};
			check16(status_word & km, ew & km);
			check1(error_summary, es);
			check1(status_word[15], es);
			check1(busy, b_old);
			check1(store.valid, pst);
			if (pst) begin
				check16(store.data & pkm, pdat & pkm);
				check1(store.to_acc, pacc);
			end
			pst = 1'b0;
			{go_old, e_old, img_old} = {go, e, load_image};
			mk_old = exc_mask;
			b_old = busy_in;
		end
		give_verdict();
	end
endmodule : fp_status_word_logic_tb
